/* File: timer16_capture_compare.sv */
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/100ps
module timer16_capture_compare #(
    parameter int ADDR_WIDTH = 8,
    parameter int CHANNELS = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic [15:0] counter_value,
    input wire logic timer_tick,
    input wire logic counter_write,
    input wire logic counting_down,
    input wire logic at_top,
    input wire logic at_bottom,
    input wire logic capture_irq_ack,
    input wire logic [CHANNELS-1:0] compare_irq_ack,
    output logic capture_irq,
    output logic [CHANNELS-1:0] compare_irq,
    output logic [CHANNELS-1:0] compare_output_state,
    output logic [15:0] top_value,
    output logic top_match
);

    function automatic logic in_set(input logic [15:0] set,
                                    input logic [3:0] mode);
        in_set = set[mode];
    endfunction

    tcc_pkg::ctrl_type ctrl;
    logic [15:0] capture_register;
    logic [7:0] holding;
    logic capture_flag;
    logic [CHANNELS-1:0] compare_flag;
    logic [15:0] compare_register [CHANNELS];
    logic [15:0] compare_buffer [CHANNELS];
    logic sample;
    logic [tcc_pkg::FILTER_SAMPLES-2:0] history;
    logic filtered;
    logic previous;
    logic blocked;

    // bus decode
    wire setup = psel & ~penable;
    wire access = psel & penable;
    wire wr = access & pwrite;
    wire rd = access & ~pwrite;
    wire [7:0] addr = paddr[7:0];
    wire sel_ctrl = addr == tcc_pkg::ADDR_CTRL;
    wire sel_status = addr == tcc_pkg::ADDR_STATUS;
    wire sel_force = addr == tcc_pkg::ADDR_FORCE;
    wire sel_cap_lo = addr == tcc_pkg::ADDR_CAPTURE_LO;
    wire sel_cap_hi = addr == tcc_pkg::ADDR_CAPTURE_HI;
    wire sel_levels = addr == tcc_pkg::ADDR_LEVELS;
    wire [CHANNELS-1:0] sel_cmp_lo;
    wire [CHANNELS-1:0] sel_cmp_hi;
    assign sel_cmp_lo = {addr == tcc_pkg::ADDR_COMPARE_B_LO,
                         addr == tcc_pkg::ADDR_COMPARE_A_LO};
    assign sel_cmp_hi = {addr == tcc_pkg::ADDR_COMPARE_B_HI,
                         addr == tcc_pkg::ADDR_COMPARE_A_HI};
    wire mapped = sel_ctrl | sel_status | sel_force | sel_cap_lo
        | sel_cap_hi | sel_levels | (|sel_cmp_lo) | (|sel_cmp_hi);

    // mode decode
    wire [3:0] mode = ctrl.waveform_mode_sel;
    wire pwm = in_set(tcc_pkg::PWM_MODES, mode);
    wire capture_top = in_set(tcc_pkg::CAPTURE_TOP_MODES, mode);
    wire fast = in_set(tcc_pkg::FAST_MODES, mode);
    wire update_point = in_set(tcc_pkg::BOTTOM_UPDATE_MODES, mode)
        ? at_bottom : at_top;

    assign pready = 1'b1;
    assign pslverr = access & ~mapped;

    localparam int ST_BITS_HI = CHANNELS;

    // read mux
    logic [31:0] next_prdata;
    always_comb begin
        next_prdata = 32'h0000_0000;
        if (sel_ctrl) begin
            next_prdata[tcc_pkg::CTRL_WIDTH-1:0] = ctrl;
        end
        if (sel_status) begin
            next_prdata[ST_BITS_HI:0] = {compare_flag, capture_flag};
        end
        if (sel_cap_lo) begin
            next_prdata[7:0] = capture_register[7:0];
        end
        if (sel_cap_hi) begin
            next_prdata[7:0] = holding;
        end
        if (sel_levels) begin
            next_prdata[CHANNELS:0] = {compare_output_state, filtered};
        end
        for (int c = 0; c < CHANNELS; c++) begin
            if (sel_cmp_lo[c]) begin
                next_prdata[7:0] = pwm ? compare_buffer[c][7:0]
                    : compare_register[c][7:0];
            end
            if (sel_cmp_hi[c]) begin
                next_prdata[7:0] = pwm ? compare_buffer[c][15:8]
                    : compare_register[c][15:8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup) begin
            prdata <= next_prdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= tcc_pkg::CTRL_RESET;
        end else if (wr && sel_ctrl) begin
            ctrl <= pwdata[tcc_pkg::CTRL_WIDTH-1:0];
        end
    end

    // shared high-byte holding register
    wire cmp_hi_wr = wr & (|sel_cmp_hi);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            holding <= 8'h00;
        end else if (wr && (sel_cap_hi || cmp_hi_wr)) begin
            holding <= pwdata[7:0];
        end else if (rd && sel_cap_lo) begin
            holding <= capture_register[15:8];
        end
    end

    // trigger path
    wire raw = ctrl.comparator_capture_select
        ? comparator_output : capture_pin;
    wire [tcc_pkg::FILTER_SAMPLES-1:0] window = {history, sample};
    wire agree_high = &window;
    wire agree_low = ~|window;
    wire source = ctrl.capture_filter_enable
        ? filtered : sample;
    wire edge_seen = (source != previous)
        && (source == ctrl.capture_rising);
    wire capture_event = edge_seen & ~capture_top;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample <= 1'b0;
            history <= '0;
            filtered <= 1'b0;
            previous <= 1'b0;
        end else if (!capture_top) begin
            sample <= raw;
            history <= window[tcc_pkg::FILTER_SAMPLES-2:0];
            if (agree_high || agree_low) begin
                filtered <= sample;
            end
            previous <= source;
        end
    end

    // capture register and flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_register <= tcc_pkg::WORD_RESET;
        end else if (capture_event) begin
            capture_register <= counter_value;
        end else if (wr && sel_cap_lo && capture_top) begin
            capture_register <= {holding, pwdata[7:0]};
        end
    end

    wire cap_clear = capture_irq_ack
        | (wr & sel_status & pwdata[tcc_pkg::ST_CAPTURE]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_flag <= 1'b0;
        end else if (capture_event) begin
            capture_flag <= 1'b1;
        end else if (cap_clear) begin
            capture_flag <= 1'b0;
        end
    end
    assign capture_irq = capture_flag & ctrl.capture_irq_enable;

    // match blocking after a counter write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            blocked <= 1'b0;
        end else if (counter_write) begin
            blocked <= 1'b1;
        end else if (timer_tick) begin
            blocked <= 1'b0;
        end
    end

    // counter top for the outside counter
    always_comb begin
        top_value = 16'hFFFF;
        if (capture_top) begin
            top_value = capture_register;
        end else if (in_set(tcc_pkg::COMPARE_TOP_MODES, mode)) begin
            top_value = compare_register[0];
        end
    end
    wire variable_top = capture_top
        | in_set(tcc_pkg::COMPARE_TOP_MODES, mode);
    assign top_match = variable_top & timer_tick & ~blocked
        & (counter_value == top_value);

    wire [1:0] action [CHANNELS];
    assign action[0] = ctrl.action_a;
    assign action[1] = ctrl.action_b;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_channel
            wire equal = counter_value == compare_register[ch];
            wire hit = equal & timer_tick & ~blocked;
            wire forced = wr & sel_force & pwdata[ch] & ~pwm;
            wire low_wr = wr & sel_cmp_lo[ch];
            wire [15:0] word = {holding, pwdata[7:0]};
            wire clear = compare_irq_ack[ch]
                | (wr & sel_status & pwdata[tcc_pkg::ST_COMPARE + ch]);
            logic next_state;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    compare_buffer[ch] <= tcc_pkg::WORD_RESET;
                end else if (low_wr) begin
                    compare_buffer[ch] <= word;
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    compare_register[ch] <= tcc_pkg::WORD_RESET;
                end else if (low_wr && !pwm) begin
                    compare_register[ch] <= word;
                end else if (pwm && timer_tick && update_point) begin
                    compare_register[ch] <= compare_buffer[ch];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    compare_flag[ch] <= 1'b0;
                end else if (hit) begin
                    compare_flag[ch] <= 1'b1;
                end else if (clear) begin
                    compare_flag[ch] <= 1'b0;
                end
            end
            assign compare_irq[ch] = compare_flag[ch]
                & ctrl.compare_irq_enable[ch];

            // output state; action read live, no buffering
            always_comb begin
                next_state = compare_output_state[ch];
                if (!pwm) begin
                    if (hit || forced) begin
                        unique case (action[ch])
                            tcc_pkg::ACT_NONE: next_state = next_state;
                            tcc_pkg::ACT_TOGGLE: next_state = ~next_state;
                            tcc_pkg::ACT_CLEAR: next_state = 1'b0;
                            tcc_pkg::ACT_SET: next_state = 1'b1;
                        endcase
                    end
                end else if (action[ch][1]) begin
                    if (fast) begin
                        if (hit) begin
                            next_state = ~action[ch][0];
                        end else if (timer_tick && at_top) begin
                            next_state = action[ch][0];
                        end
                    end else if (hit) begin
                        next_state = counting_down ^ ~action[ch][0];
                    end
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    compare_output_state[ch] <= 1'b0;
                end else begin
                    compare_output_state[ch] <= next_state;
                end
            end
        end
    endgenerate

endmodule // timer16_capture_compare

/* File: tcc_pkg.sv */
package tcc_pkg;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FORCE = 8'h08;
    localparam logic [7:0] ADDR_CAPTURE_LO = 8'h0C;
    localparam logic [7:0] ADDR_CAPTURE_HI = 8'h10;
    localparam logic [7:0] ADDR_COMPARE_A_LO = 8'h14;
    localparam logic [7:0] ADDR_COMPARE_A_HI = 8'h18;
    localparam logic [7:0] ADDR_COMPARE_B_LO = 8'h1C;
    localparam logic [7:0] ADDR_COMPARE_B_HI = 8'h20;
    localparam logic [7:0] ADDR_LEVELS = 8'h24;

    // status bit positions and control register width
    localparam int ST_CAPTURE = 0;
    localparam int ST_COMPARE = 1;
    localparam int CTRL_WIDTH = 14;

    // reset values
    localparam logic [13:0] CTRL_RESET = 14'h0000;
    localparam logic [15:0] WORD_RESET = 16'h0000;

    // mode sets, one bit per waveform mode number
    localparam logic [15:0] PWM_MODES = 16'hCFEE;
    localparam logic [15:0] CAPTURE_TOP_MODES = 16'h5500;
    localparam logic [15:0] BOTTOM_UPDATE_MODES = 16'h0300;
    localparam logic [15:0] FAST_MODES = 16'hC0E0;
    localparam logic [15:0] COMPARE_TOP_MODES = 16'h8A10;

    // compare output actions
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // noise filter window
    localparam int FILTER_SAMPLES = 4;

    typedef struct packed {
        logic [1:0] compare_irq_enable;
        logic capture_irq_enable;
        logic [1:0] action_b;
        logic [1:0] action_a;
        logic [3:0] waveform_mode_sel;
        logic capture_rising;
        logic capture_filter_enable;
        logic comparator_capture_select;
    } ctrl_type;

endpackage

/* File: timer16_capture_compare_checker.sv */
`timescale 1ns/100ps
module timer16_capture_compare_checker #(
    parameter int ADDR_WIDTH = 8,
    parameter int CHANNELS = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic capture_pin,
    input wire logic comparator_output,
    input wire logic [15:0] counter_value,
    input wire logic timer_tick,
    input wire logic counter_write,
    input wire logic capture_irq_ack,
    input wire logic [CHANNELS-1:0] compare_irq_ack,
    input wire logic capture_irq,
    input wire logic [CHANNELS-1:0] compare_irq,
    input wire logic [CHANNELS-1:0] compare_output_state,
    input wire logic [15:0] top_value,
    input wire logic top_match
);
    logic p_pin, p_cmp, pend;
    logic [3:0] quiet;
    wire wr = psel && penable && pwrite;
    wire moved = wr || capture_pin != p_pin || comparator_output != p_cmp;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // pend: a counter write waits for the tick it blanks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            p_pin <= 1'b0;
            p_cmp <= 1'b0;
            pend <= 1'b0;
            quiet <= 4'h0;
        end else begin
            p_pin <= capture_pin;
            p_cmp <= comparator_output;
            pend <= counter_write || (pend && !timer_tick);
            quiet <= moved ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
        end
    end
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_err_data: assert property (psel && penable && !pwrite && pslverr
        |-> prdata == 32'h0) else $error("unmapped read not zero");
    a_match_cause: assert property (top_match |-> timer_tick
        && counter_value == top_value) else $error("top match no cause");
    a_write_blocks: assert property (top_match |-> !pend)
        else $error("match after counter write");
    a_flag_cause: assert property ($rose(compare_irq[0])
        |-> $past(timer_tick || wr)) else $error("compare irq no cause");
    a_ack_clear: assert property (compare_irq_ack[0]
        && !timer_tick |=> !compare_irq[0]) else $error("ack kept irq");
    a_w1c_clear: assert property (wr && pwdata[1]
        && paddr[7:0] == tcc_pkg::ADDR_STATUS && !timer_tick
        |=> !compare_irq[0]) else $error("write one kept irq");
    a_cap_ack: assert property (capture_irq_ack && quiet > 4'h8
        |=> !capture_irq) else $error("capture ack kept irq");
    a_out_cause: assert property ($changed(compare_output_state)
        |-> $past(timer_tick || wr)) else $error("output moved alone");
    a_top_cause: assert property ($changed(top_value)
        |-> $past(timer_tick || wr)) else $error("top moved alone");
    c_top_match: cover property (top_match);
    c_capture: cover property ($rose(capture_irq));
    c_compare: cover property ($rose(compare_irq[0]));
    c_force: cover property (wr && paddr[7:0] == tcc_pkg::ADDR_FORCE);
endmodule // timer16_capture_compare_checker
bind timer16_capture_compare timer16_capture_compare_checker #(
    .ADDR_WIDTH(ADDR_WIDTH), .CHANNELS(CHANNELS)) chk_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
    .comparator_output(comparator_output), .counter_value(counter_value),
    .timer_tick(timer_tick), .counter_write(counter_write),
    .capture_irq_ack(capture_irq_ack), .compare_irq_ack(compare_irq_ack),
    .capture_irq(capture_irq), .compare_irq(compare_irq),
    .compare_output_state(compare_output_state), .top_value(top_value),
    .top_match(top_match));

/* File: event_source.sv */
`timescale 1ns/100ps
// external event pin and comparator output, driven as port logic would
module event_source (
    input wire logic pin_req,
    input wire logic cmp_req,
    output logic capture_pin,
    output logic comparator_output
);
    assign capture_pin = pin_req;
    assign comparator_output = cmp_req;
endmodule // event_source

/* File: timer16_capture_compare_test.sv */
`timescale 1ns/100ps
module timer16_capture_compare_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rv;
    logic pready, pslverr, ev, pin_req = 0, cmp_req = 0;
    logic capture_pin, comparator_output, capture_irq, top_match;
    logic [15:0] counter_value = 16'h0, top_value;
    logic timer_tick = 0, counter_write = 0, at_top = 0, cap_ack = 0;
    logic at_bottom = 0;
    logic [1:0] cmp_ack = 2'h0, compare_irq, compare_output_state;
    int num_errors = 0, n_tests = 0;
    always #50 pclk = ~pclk;
    event_source event_source_inst (.pin_req(pin_req), .cmp_req(cmp_req),
        .capture_pin(capture_pin), .comparator_output(comparator_output));
    timer16_capture_compare timer16_capture_compare_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .capture_pin(capture_pin),
        .comparator_output(comparator_output),
        .counter_value(counter_value), .timer_tick(timer_tick),
        .counter_write(counter_write), .counting_down(1'b0),
        .at_top(at_top), .at_bottom(at_bottom), .capture_irq_ack(cap_ack),
        .compare_irq_ack(cmp_ack), .capture_irq(capture_irq),
        .compare_irq(compare_irq),
        .compare_output_state(compare_output_state),
        .top_value(top_value), .top_match(top_match));
    task chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            num_errors++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task ap(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        ap(1'b1, a, d);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] e);
        ap(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    task tick;
        @(posedge pclk) timer_tick <= 1'b1;
        @(posedge pclk) timer_tick <= 1'b0;
        #1;
    endtask
    // raise a trigger and count clocks until the capture shows
    task lat(input logic c, input int e);
        int n;
        n = 0;
        @(posedge pclk);
        if (c) cmp_req <= 1'b1;
        else pin_req <= 1'b1;
        while (capture_irq !== 1'b1 && n < 20) begin
            @(posedge pclk);
            #1;
            n++;
        end
        chk(n, e);
    endtask
    task give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        num_errors++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rc(tcc_pkg::ADDR_CTRL, 32'h0);
        rc(tcc_pkg::ADDR_STATUS, 32'h0);
        chk(top_value, 16'hFFFF);
        $display("reset test done");
        wr(tcc_pkg::ADDR_CTRL, 32'h804);
        counter_value <= 16'h1234;
        lat(1'b0, 2);
        rc(tcc_pkg::ADDR_STATUS, 32'h1);
        counter_value <= 16'hABCD;
        rc(tcc_pkg::ADDR_CAPTURE_LO, 32'h34);
        rc(tcc_pkg::ADDR_CAPTURE_HI, 32'h12);
        @(posedge pclk) pin_req <= 1'b0;
        wr(tcc_pkg::ADDR_STATUS, 32'h1);
        rc(tcc_pkg::ADDR_STATUS, 32'h0);
        lat(1'b0, 2);
        rc(tcc_pkg::ADDR_CAPTURE_LO, 32'hCD);
        rc(tcc_pkg::ADDR_CAPTURE_HI, 32'hAB);
        $display("capture test done");
        wr(tcc_pkg::ADDR_CTRL, 32'h806);
        @(posedge pclk) pin_req <= 1'b0;
        repeat (10) @(posedge pclk);
        cap_ack <= 1'b1;
        @(posedge pclk) cap_ack <= 1'b0;
        pin_req <= 1'b1;
        repeat (3) @(posedge pclk);
        pin_req <= 1'b0;
        repeat (10) @(posedge pclk);
        rc(tcc_pkg::ADDR_STATUS, 32'h0);
        lat(1'b0, 6);
        wr(tcc_pkg::ADDR_CTRL, 32'h805);
        wr(tcc_pkg::ADDR_STATUS, 32'h1);
        lat(1'b1, 2);
        $display("filter and source test done");
        wr(tcc_pkg::ADDR_CTRL, 32'h1000);
        wr(tcc_pkg::ADDR_STATUS, 32'h7);
        wr(tcc_pkg::ADDR_COMPARE_A_HI, 32'h01);
        wr(tcc_pkg::ADDR_COMPARE_A_LO, 32'h80);
        rc(tcc_pkg::ADDR_COMPARE_A_LO, 32'h80);
        rc(tcc_pkg::ADDR_COMPARE_A_HI, 32'h01);
        counter_value <= 16'h0180;
        tick();
        chk(compare_irq, 2'h1);
        rc(tcc_pkg::ADDR_STATUS, 32'h2);
        @(posedge pclk) cmp_ack <= 2'h1;
        @(posedge pclk) cmp_ack <= 2'h0;
        #1;
        chk(compare_irq, 2'h0);
        @(posedge pclk) counter_write <= 1'b1;
        @(posedge pclk) counter_write <= 1'b0;
        tick();
        chk(compare_irq, 2'h0);
        tick();
        chk(compare_irq, 2'h1);
        $display("compare test done");
        wr(tcc_pkg::ADDR_STATUS, 32'h7);
        wr(tcc_pkg::ADDR_CTRL, 32'h1080);
        wr(tcc_pkg::ADDR_FORCE, 32'h1);
        #1;
        chk(compare_output_state, 2'h1);
        rc(tcc_pkg::ADDR_STATUS, 32'h0);
        wr(tcc_pkg::ADDR_CTRL, 32'h10A0);
        #1;
        chk(compare_output_state, 2'h1);
        chk(top_value, 16'h0180);
        wr(tcc_pkg::ADDR_CTRL, 32'h1120);
        wr(tcc_pkg::ADDR_FORCE, 32'h1);
        #1;
        chk(compare_output_state, 2'h0);
        $display("force test done");
        wr(tcc_pkg::ADDR_CTRL, 32'h78);
        wr(tcc_pkg::ADDR_COMPARE_A_HI, 32'h02);
        wr(tcc_pkg::ADDR_COMPARE_A_LO, 32'h00);
        chk(top_value, 16'h0180);
        @(posedge pclk) counter_write <= 1'b1;
        @(posedge pclk) counter_write <= 1'b0;
        at_top <= 1'b1;
        @(posedge pclk) timer_tick <= 1'b1;
        #1;
        chk(top_match, 1'b0);
        @(posedge pclk) timer_tick <= 1'b0;
        #1;
        at_top <= 1'b0;
        chk(top_value, 16'h0200);
        @(posedge pclk) counter_value <= 16'h0200;
        @(posedge pclk) timer_tick <= 1'b1;
        #1;
        chk(top_match, 1'b1);
        @(posedge pclk) timer_tick <= 1'b0;
        wr(tcc_pkg::ADDR_CTRL, 32'h48);
        wr(tcc_pkg::ADDR_COMPARE_A_HI, 32'h03);
        wr(tcc_pkg::ADDR_COMPARE_A_LO, 32'h00);
        rc(tcc_pkg::ADDR_COMPARE_A_HI, 32'h03);
        at_top <= 1'b1;
        tick();
        at_top <= 1'b0;
        chk(top_value, 16'h0200);
        @(posedge pclk) at_bottom <= 1'b1;
        tick();
        at_bottom <= 1'b0;
        chk(top_value, 16'h0300);
        wr(tcc_pkg::ADDR_CTRL, 32'h864);
        @(posedge pclk) pin_req <= 1'b0;
        repeat (8) @(posedge pclk);
        pin_req <= 1'b1;
        repeat (10) @(posedge pclk);
        chk(capture_irq, 1'b0);
        rc(8'h28, 32'h0);
        chk(ev, 1'b1);
        $display("buffer and map test done");
        give_verdict();
    end
endmodule // timer16_capture_compare_test
